// ===== pulse_shaper.sv
// Retriggerable pulse generator: width counted in steps.
// Assumes trig and step are single-cycle qualifiers in the pixel domain.
`timescale 1ns/100ps
module pulse_shaper (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic trig,
   input wire logic step,
   input wire logic [15:0] width,
   output logic active
);

   // ----------------------------------------------------------------
   // Remaining count
   // ----------------------------------------------------------------
   logic [15:0] remain;
   logic [15:0] next_remain;

   // Load on trigger; a new trigger restarts the pulse
   always_comb begin
      next_remain = remain;
      if (trig) begin
         next_remain = width;
      end else if (step && remain != 16'h0000) begin
         next_remain = remain - 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         remain <= sync_out_pkg::COUNT_RST;
      end else begin
         remain <= next_remain;
      end
   end

   assign active = (remain != 16'h0000);

endmodule : pulse_shaper

// ===== sync_out_pkg.sv
// Shared constants and types for the sync output stage.
// Assumes a single pixel clock domain and a simple byte-wide register port.
package sync_out_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] VS_DUR_A_OFS = 8'h14;
   localparam logic [7:0] VS_DUR_B_OFS = 8'h15;
   localparam logic [7:0] SLICER_SEL_OFS = 8'h1D;
   localparam logic [7:0] VS_DUR_A_RST = 8'h00;
   localparam logic [7:0] VS_DUR_B_RST = 8'h00;
   localparam logic [7:0] SLICER_SEL_RST = 8'h00;
   localparam int SLICER_SEL_LSB = 0;

   // ----------------------------------------------------------------
   // Reset values of the outputs and counters
   // ----------------------------------------------------------------
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic STRAP_RST = 1'b0;

   // Slicer output sources, in select-field order
   typedef enum logic [1:0] {
      SEL_RAW_GREEN,
      SEL_RAW_LINE,
      SEL_REGEN_LINE,
      SEL_PLL_LOOP_FILTER_NODE_LINE
   } slicer_src_t;

   // Shared-pin phases: strap sampling, then sync drive
   typedef enum logic {
      STRAP_WAIT,
      STRAP_RUN
   } strap_state_t;

   // Incoming sync levels from the separator and clock generator
   typedef struct packed {
      logic green_embedded_sync;
      logic line_sync_raw;
      logic line_sync_regen;
      logic line_sync_pll_loop_filter_node;
      logic frame_sync_direct;
      logic frame_sync_sep;
   } sync_in_t;

endpackage : sync_out_pkg

// ===== sync_output_stage.sv
// Sync output stage: line sync regeneration, frame sync, slicer mux, field flag.
// Assumes all inputs are synchronous to the pixel clock clk and that the
// shared frame sync pin is resolved outside from oe_b and the pull resistor.
`timescale 1ns/100ps

// Behaviour
// - Line sync out is regenerated from filtered sync, polarity and width programmable.
// - Line sync out keeps fixed latency relative to pixel clock and data.
// - Frame sync out is separated composite sync or direct pass-through.
// - One polarity bit inverts frame sync out.
// - Frame sync follows source by default; width optionally from 0x14/0x15.
// - Two-bit field at 0x1D picks one of four slicer output sources.
// - Slicer output is only muxed, never further processed.
// - Field flag reports odd or even field for interlaced input.
// - Strap sampling on the shared pin does not disturb frame sync.
// - Shared pin read after reset as bus address LSB; board sets pull.
module sync_output_stage (
   input wire logic clk,
   input wire logic rst_b,
   input sync_out_pkg::sync_in_t sync_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] line_sync_width,
   input wire logic line_sync_invert,
   input wire logic frame_sync_invert,
   input wire logic frame_sync_use_sep,
   input wire logic frame_width_override,
   input wire logic frame_sync_pin_in,
   output logic frame_sync_out,
   output logic frame_sync_oe_b,
   output logic bus_addr_lsb_strap,
   output logic line_sync_out,
   output logic slicer_sync_out,
   output logic field_odd
);

   // Rising edge helper, used for both sync paths
   function automatic logic rising(input logic prev, input logic cur);
      rising = cur & ~prev;
   endfunction : rising

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] vs_dur_a;
   logic [7:0] vs_dur_b;
   logic [7:0] slicer_sel_reg;
   logic [7:0] next_vs_dur_a;
   logic [7:0] next_vs_dur_b;
   logic [7:0] next_slicer_sel_reg;
   logic [7:0] next_reg_rdata;
   sync_out_pkg::slicer_src_t slicer_sel;

   // Write decode and read mux; unmapped reads return zero
   always_comb begin
      next_vs_dur_a = vs_dur_a;
      next_vs_dur_b = vs_dur_b;
      next_slicer_sel_reg = slicer_sel_reg;
      if (reg_wr) begin
         case (reg_addr)
            sync_out_pkg::VS_DUR_A_OFS: next_vs_dur_a = reg_wdata;
            sync_out_pkg::VS_DUR_B_OFS: next_vs_dur_b = reg_wdata;
            sync_out_pkg::SLICER_SEL_OFS: next_slicer_sel_reg = reg_wdata;
            default: next_vs_dur_a = vs_dur_a;
         endcase
      end
      case (reg_addr)
         sync_out_pkg::VS_DUR_A_OFS: next_reg_rdata = vs_dur_a;
         sync_out_pkg::VS_DUR_B_OFS: next_reg_rdata = vs_dur_b;
         sync_out_pkg::SLICER_SEL_OFS: next_reg_rdata = slicer_sel_reg;
         default: next_reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vs_dur_a <= sync_out_pkg::VS_DUR_A_RST;
         vs_dur_b <= sync_out_pkg::VS_DUR_B_RST;
         slicer_sel_reg <= sync_out_pkg::SLICER_SEL_RST;
         reg_rdata <= 8'h00;
      end else begin
         vs_dur_a <= next_vs_dur_a;
         vs_dur_b <= next_vs_dur_b;
         slicer_sel_reg <= next_slicer_sel_reg;
         reg_rdata <= next_reg_rdata;
      end
   end

   // Select field sits in the low two bits
   assign slicer_sel = sync_out_pkg::slicer_src_t'(
      slicer_sel_reg[sync_out_pkg::SLICER_SEL_LSB +: 2]);

   // ----------------------------------------------------------------
   // Line sync regeneration
   // ----------------------------------------------------------------
   logic line_regen_q;
   logic line_trig;
   logic line_active;
   logic next_line_sync_out;

   assign line_trig = rising(line_regen_q, sync_in.line_sync_regen);

   pulse_shaper u_line_pulse (
      .clk(clk),
      .rst_b(rst_b),
      .trig(line_trig),
      .step(1'b1),
      .width({8'h00, line_sync_width}),
      .active(line_active)
   );

   // Inversion after the width logic; fixed two-clock latency keeps
   // the output in step with the pixel data pipeline
   assign next_line_sync_out = line_active ^ line_sync_invert;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_regen_q <= 1'b0;
         line_sync_out <= 1'b0;
      end else begin
         line_regen_q <= sync_in.line_sync_regen;
         line_sync_out <= next_line_sync_out;
      end
   end

   // ----------------------------------------------------------------
   // Frame sync path
   // ----------------------------------------------------------------
   logic frame_src;
   logic frame_src_q;
   logic frame_trig;
   logic frame_active;
   logic frame_pre;
   logic next_frame_sync_out;

   // Separated or pass-through source
   assign frame_src = frame_sync_use_sep ? sync_in.frame_sync_sep
                                         : sync_in.frame_sync_direct;
   assign frame_trig = rising(frame_src_q, frame_src);

   // Width override counts regenerated line edges
   pulse_shaper u_frame_pulse (
      .clk(clk),
      .rst_b(rst_b),
      .trig(frame_trig),
      .step(line_trig),
      .width({vs_dur_a, vs_dur_b}),
      .active(frame_active)
   );

   // Default keeps source placement and width, delayed to match
   assign frame_pre = frame_width_override ? frame_active : frame_src_q;
   assign next_frame_sync_out = frame_pre ^ frame_sync_invert;

   // Drives regardless of strap phase, so sampling never disturbs it
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_src_q <= 1'b0;
         frame_sync_out <= 1'b0;
      end else begin
         frame_src_q <= frame_src;
         frame_sync_out <= next_frame_sync_out;
      end
   end

   // ----------------------------------------------------------------
   // Shared pin strap capture
   // ----------------------------------------------------------------
   sync_out_pkg::strap_state_t strap_state;
   sync_out_pkg::strap_state_t next_strap_state;
   logic next_strap;

   // One clock with the driver off lets the pull resistor be sampled
   always_comb begin
      next_strap_state = strap_state;
      next_strap = bus_addr_lsb_strap;
      case (strap_state)
         sync_out_pkg::STRAP_WAIT: begin
            next_strap = frame_sync_pin_in;
            next_strap_state = sync_out_pkg::STRAP_RUN;
         end
         sync_out_pkg::STRAP_RUN: next_strap_state = sync_out_pkg::STRAP_RUN;
         default: next_strap_state = sync_out_pkg::STRAP_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         strap_state <= sync_out_pkg::STRAP_WAIT;
         bus_addr_lsb_strap <= sync_out_pkg::STRAP_RST;
      end else begin
         strap_state <= next_strap_state;
         bus_addr_lsb_strap <= next_strap;
      end
   end

   assign frame_sync_oe_b = (strap_state == sync_out_pkg::STRAP_WAIT);

   // ----------------------------------------------------------------
   // Slicer output mux
   // ----------------------------------------------------------------
   logic next_slicer;

   // Plain selection only; no filtering or separation here
   always_comb begin
      case (slicer_sel)
         sync_out_pkg::SEL_RAW_GREEN: next_slicer = sync_in.green_embedded_sync;
         sync_out_pkg::SEL_RAW_LINE: next_slicer = sync_in.line_sync_raw;
         sync_out_pkg::SEL_REGEN_LINE: next_slicer = sync_in.line_sync_regen;
         sync_out_pkg::SEL_PLL_LOOP_FILTER_NODE_LINE: next_slicer = sync_in.line_sync_pll_loop_filter_node;
         default: next_slicer = sync_in.green_embedded_sync;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         slicer_sync_out <= 1'b0;
      end else begin
         slicer_sync_out <= next_slicer;
      end
   end

   // ----------------------------------------------------------------
   // Odd/even field detection
   // ----------------------------------------------------------------
   logic [15:0] pix_cnt;
   logic [15:0] line_len;
   logic [15:0] next_pix_cnt;
   logic [15:0] next_line_len;
   logic next_field_odd;

   // Frame edge in first half of a line marks the odd field; an
   // edge near mid-line is the half-line offset of the even field
   always_comb begin
      next_pix_cnt = pix_cnt + 16'h0001;
      next_line_len = line_len;
      next_field_odd = field_odd;
      if (line_trig) begin
         next_pix_cnt = 16'h0000;
         next_line_len = pix_cnt;
      end
      if (frame_trig) begin
         next_field_odd = (pix_cnt < {1'b0, line_len[15:1]});
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pix_cnt <= sync_out_pkg::COUNT_RST;
         line_len <= sync_out_pkg::COUNT_RST;
         field_odd <= 1'b0;
      end else begin
         pix_cnt <= next_pix_cnt;
         line_len <= next_line_len;
         field_odd <= next_field_odd;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_line_start;
      @(posedge clk) disable iff (!rst_b)
      line_trig && line_sync_width != 8'h00 && $stable(line_sync_invert)
      |-> ##2 (line_sync_out != line_sync_invert);
   endproperty
   a_line_start: assert property (p_line_start)
      else $error("line sync pulse did not start two clocks after edge");

   property p_line_width1;
      @(posedge clk) disable iff (!rst_b)
      line_trig && line_sync_width == 8'h01 ##1 !line_trig
      |-> ##1 !line_active;
   endproperty
   a_line_width1: assert property (p_line_width1)
      else $error("one-clock line sync pulse ran long");

   property p_frame_pass;
      @(posedge clk) disable iff (!rst_b)
      !frame_width_override && $past(!frame_width_override)
      |-> frame_sync_out == ($past(frame_src, 2) ^ $past(frame_sync_invert));
   endproperty
   a_frame_pass: assert property (p_frame_pass)
      else $error("frame sync did not follow its source");

   property p_frame_pol;
      @(posedge clk) disable iff (!rst_b)
      frame_width_override && !frame_active && $stable(frame_width_override)
      |=> frame_sync_out == $past(frame_sync_invert);
   endproperty
   a_frame_pol: assert property (p_frame_pol)
      else $error("frame sync idle level wrong for polarity");

   property p_frame_width;
      @(posedge clk) disable iff (!rst_b)
      frame_trig && {vs_dur_a, vs_dur_b} != 16'h0000 |=> frame_active;
   endproperty
   a_frame_width: assert property (p_frame_width)
      else $error("frame width pulse not started");

   property p_slicer;
      @(posedge clk) disable iff (!rst_b)
      slicer_sel == sync_out_pkg::SEL_RAW_LINE
      |=> slicer_sync_out == $past(sync_in.line_sync_raw);
   endproperty
   a_slicer: assert property (p_slicer)
      else $error("slicer output not raw line sync");

   property p_field;
      @(posedge clk) disable iff (!rst_b)
      frame_trig && pix_cnt < {1'b0, line_len[15:1]} |=> field_odd;
   endproperty
   a_field: assert property (p_field)
      else $error("field flag not odd for early frame edge");

   // Flag may only move on a frame edge, never between them
   property p_field_hold;
      @(posedge clk) disable iff (!rst_b)
      !frame_trig |=> field_odd == $past(field_odd);
   endproperty
   a_field_hold: assert property (p_field_hold)
      else $error("field flag changed without a frame edge");

   property p_strap;
      @(posedge clk) disable iff (!rst_b)
      strap_state == sync_out_pkg::STRAP_WAIT
      |=> bus_addr_lsb_strap == $past(frame_sync_pin_in) && !frame_sync_oe_b;
   endproperty
   a_strap: assert property (p_strap)
      else $error("strap not captured or pin not driven after capture");

endmodule : sync_output_stage

// ===== sync_sink.sv
// Far-side model: board pull resistor on the shared frame sync pin.
// Assumes the stage releases the pin (oe_b high) while it samples the strap.
`timescale 1ns/100ps
module sync_sink (
   input wire logic frame_sync_out,
   input wire logic frame_sync_oe_b,
   input wire logic pull_up,
   output logic pin_level
);
   // ----------------------------------------------------------------
   // Pin resolution
   // ----------------------------------------------------------------
   // A released pin goes to the pull level, not to the last driven value
   assign pin_level = frame_sync_oe_b ? pull_up : frame_sync_out;
endmodule : sync_sink

// ===== tb_top.sv
// Self-checking bench for the sync output stage, random plus corner cases.
// Assumes one 40 MHz pixel clock and the board pull model in sync_sink.
`timescale 1ns/100ps
module tb_top;
   // ----------------------------------------------------------------
   // Signals and instances
   // ----------------------------------------------------------------
   logic clk, rst_b, reg_wr, line_sync_invert, frame_sync_invert, frame_sync_use_sep;
   logic frame_width_override, pin_level, pull_up, frame_sync_out, frame_sync_oe_b;
   logic bus_addr_lsb_strap, line_sync_out, slicer_sync_out, field_odd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, line_sync_width;
   sync_out_pkg::sync_in_t sync_in;
   logic [31:0] seed;
   int err_total, comparisons;

   sync_output_stage u_sync_output_stage (.clk(clk), .rst_b(rst_b), .sync_in(sync_in),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .line_sync_width(line_sync_width), .line_sync_invert(line_sync_invert),
      .frame_sync_invert(frame_sync_invert), .frame_sync_use_sep(frame_sync_use_sep),
      .frame_width_override(frame_width_override), .frame_sync_pin_in(pin_level),
      .frame_sync_out(frame_sync_out), .frame_sync_oe_b(frame_sync_oe_b),
      .bus_addr_lsb_strap(bus_addr_lsb_strap), .line_sync_out(line_sync_out),
      .slicer_sync_out(slicer_sync_out), .field_odd(field_odd));
   sync_sink u_sync_sink (.frame_sync_out(frame_sync_out), .frame_sync_oe_b(frame_sync_oe_b),
      .pull_up(pull_up), .pin_level(pin_level));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Free-running pixel clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Line pulse is active from 2 to width+1 clocks after the edge
   function automatic logic exp_line(input int k, input int w, input logic inv);
      return ((k >= 2) && (k <= w + 1)) ^ inv;
   endfunction : exp_line

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk1

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8

   // One-cycle write strobe; returns on the edge that takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      @(posedge clk);
      #1 chk8(reg_rdata, e);
   endtask : rd_chk

   // Reset with a given strap pull, then check strap and register defaults
   task automatic reset_chk(input logic p);
      @(posedge clk);
      rst_b <= 1'b0;
      pull_up <= p;
      repeat (8) @(posedge clk);
      #1 chk1(frame_sync_oe_b, 1'b1);
      @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk1(bus_addr_lsb_strap, p);
      chk1(frame_sync_oe_b, 1'b0);
      rd_chk(sync_out_pkg::VS_DUR_A_OFS, sync_out_pkg::VS_DUR_A_RST);
      rd_chk(sync_out_pkg::VS_DUR_B_OFS, sync_out_pkg::VS_DUR_B_RST);
      rd_chk(sync_out_pkg::SLICER_SEL_OFS, sync_out_pkg::SLICER_SEL_RST);
      $display("test reset done");
   endtask : reset_chk

   // Frame edge at a given offset into a 20-clock line
   task automatic field_case(input int off, input logic e);
      sync_out_pkg::sync_in_t v;
      for (int n = 0; n <= 60 + off; n++) begin
         @(posedge clk);
         v = '0;
         v.line_sync_regen = (n % 20 == 0);
         v.frame_sync_direct = (n == 60 + off);
         sync_in <= v;
      end
      repeat (4) @(posedge clk);
      #1 chk1(field_odd, e);
   endtask : field_case

   // Hang guard
   initial begin
      #1000000;
      err_total++;
      test_done();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] r;
      logic [5:0] v, v1, v2;
      int w, nw;
      logic inv;
      seed = 32'hCC11FBA0;
      err_total = 0;
      comparisons = 0;
      rst_b = 1'b0;
      sync_in = '0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_wdata = 8'h00;
      line_sync_width = 8'h00;
      line_sync_invert = 1'b0;
      frame_sync_invert = 1'b0;
      frame_sync_use_sep = 1'b0;
      frame_width_override = 1'b0;
      pull_up = 1'b0;
      reset_chk(1'b1);
      reset_chk(1'b0);
      // Back-to-back write and read, then an unmapped place
      r = 8'(rnd());
      wr(sync_out_pkg::VS_DUR_A_OFS, r);
      rd_chk(sync_out_pkg::VS_DUR_A_OFS, r);
      r = 8'(rnd());
      wr(sync_out_pkg::VS_DUR_B_OFS, r);
      rd_chk(sync_out_pkg::VS_DUR_B_OFS, r);
      wr(8'h16, 8'(rnd()));
      rd_chk(8'h16, 8'h00);
      $display("test registers done");
      // Every slicer source and frame mode under random sync levels
      for (int m = 0; m < 4; m++) begin
         r = 8'(rnd());
         wr(sync_out_pkg::SLICER_SEL_OFS, {r[7:2], 2'(m)});
         frame_sync_use_sep <= m[0];
         frame_sync_invert <= m[1];
         pull_up <= 1'b1;
         for (int k = 0; k < 24; k++) begin
            @(posedge clk);
            v = 6'(rnd());
            sync_in <= v;
            #1;
            if (k >= 3) begin
               chk1(slicer_sync_out, v1[5 - m]);
               chk1(frame_sync_out, (m[0] ? v2[0] : v2[1]) ^ m[1]);
               chk1(bus_addr_lsb_strap, 1'b0);
            end
            v2 = v1;
            v1 = v;
         end
      end
      $display("test slicer and frame done");
      // Line pulses: zero, full and one-clock width, random widths and polarity
      for (int c = 0; c < 6; c++) begin
         w = (c == 0) ? 0 : (c == 1) ? 255 : (c == 2) ? 1 : int'(rnd() % 8) + 1;
         inv = 1'(rnd());
         @(posedge clk);
         sync_in <= '0;
         line_sync_width <= 8'(w);
         line_sync_invert <= inv;
         repeat (4) @(posedge clk);
         sync_in <= 6'h08;
         for (int k = 1; k <= w + 3; k++) begin
            @(posedge clk);
            sync_in <= '0;
            #1 chk1(line_sync_out, exp_line(k, w, inv));
         end
      end
      $display("test line sync done");
      @(posedge clk);
      frame_sync_use_sep <= 1'b0;
      frame_sync_invert <= 1'b0;
      field_case(3, 1'b1);
      field_case(15, 1'b0);
      $display("test field done");
      // Width from registers, counted in line edges
      nw = int'(rnd() % 3) + 1;
      wr(sync_out_pkg::VS_DUR_A_OFS, 8'h00);
      wr(sync_out_pkg::VS_DUR_B_OFS, 8'(nw));
      frame_width_override <= 1'b1;
      for (int n = 0; n <= 10 * nw + 8; n++) begin
         @(posedge clk);
         v = '0;
         v[3] = (n % 10 == 0);
         v[1] = (n == 5);
         sync_in <= v;
         #1;
         if (n == 8 || n == 10 * nw - 1) begin
            chk1(frame_sync_out, 1'b1);
         end
         if (n == 10 * nw + 8) begin
            chk1(frame_sync_out, 1'b0);
         end
      end
      $display("test frame width done");
      test_done();
   end
endmodule : tb_top
